//--- rtl/dit_input_terms.sv
// dit_input_terms: terminal function decoder with an axi4-lite register slave
// assumes terminals and drive status are synchronous; one cycle of latency
// Operation
// - aux-clear input zeroes auxiliary frequency
// - command/direction jog, command low ignored
// - separate jog-1 inputs disable command/direction
// - two selects choose four ramp sets
// - single select chooses between two sets
// - ramp-shape input active gives s curve
// - terminal ramp shape beats stored method
// - ramp-inhibit holds speed, stop still obeyed
// - ramp-inhibit ignored while decelerating to stop
// - force-normal overrides other frequency sources except jog
// - sequencer-memory reset clears stored state
// - pid pause keeps present frequency
// - pid inhibit falls to lower mode
// - priority jog, pid, multi-speed, sequencer, normal
// - integral hold freezes pid integrator
// - integral clear zeroes pid integrator
// - manual swing input enters wobble
// - swing reset clears wobble state
// - stop-brake dc brakes until motor stops
// - external interrupt cuts output when running
// - interrupt release restarts with flying start
// - freewheel input cuts output, load coasts
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dit_input_terms
	import dit_pkg::*;
#(
	parameter int N_TERM = DIT_N_TERM
) (
	input  wire logic              clk_sys,        // 100 MHz clock
	input  wire logic              rst_n,          // sync reset, active low
	input  wire logic [N_TERM-1:0] term_in,        // terminal levels, 1 = closed
	input  wire dit_drive_t        drv,            // drive status
	output dit_cmd_t               cmd,            // commands to drive
	input  wire logic [DIT_AW-1:0] s_axi_awaddr,   // write address
	input  wire logic              s_axi_awvalid,  // write address valid
	output logic                   s_axi_awready,  // write address ready
	input  wire logic [31:0]       s_axi_wdata,    // write data
	input  wire logic [3:0]        s_axi_wstrb,    // byte strobes
	input  wire logic              s_axi_wvalid,   // write data valid
	output logic                   s_axi_wready,   // write data ready
	output logic [1:0]             s_axi_bresp,    // write response
	output logic                   s_axi_bvalid,   // write response valid
	input  wire logic              s_axi_bready,   // write response ready
	input  wire logic [DIT_AW-1:0] s_axi_araddr,   // read address
	input  wire logic              s_axi_arvalid,  // read address valid
	output logic                   s_axi_arready,  // read address ready
	output logic [31:0]            s_axi_rdata,    // read data
	output logic [1:0]             s_axi_rresp,    // read response
	output logic                   s_axi_rvalid,   // read data valid
	input  wire logic              s_axi_rready    // read data ready
);

	dit_state_t          s_reg;
	dit_state_t          s_next;
	logic [DIT_N_FN-1:0] fa;
	logic [DIT_N_FN-1:0] fasg;
	logic [DIT_N_TERM-1:0][DIT_FN_W-1:0] fcode;
	logic [N_TERM-1:0][DIT_FN_W-1:0]     tcode;

	assign fcode = s_reg.func;

	genvar g;
	generate
		for (g = 0; g < N_TERM; g++) begin : g_code
			// terminals above the register map carry no function
			if (g < DIT_N_TERM) begin : g_map
				assign tcode[g] = fcode[g];
			end else begin : g_none
				assign tcode[g] = '0;
			end
		end
	endgenerate

	dit_term_decode #(
		.N_TERM (N_TERM)
	) u_decode (
		.level    (term_in),
		.code     (tcode),
		.active   (fa),
		.assigned (fasg)
	);

	function automatic logic addr_ok(input logic [DIT_AW-1:0] a);
		return (a == DIT_OFS_FUNC_LO) || (a == DIT_OFS_FUNC_HI)
			|| (a == DIT_OFS_CFG) || (a == DIT_OFS_STAT);
	endfunction : addr_ok

	function automatic logic [31:0] rd_word(input logic [DIT_AW-1:0] a,
		input dit_state_t st);
		logic [31:0] w;
		w = '0;
		case (a)
			DIT_OFS_FUNC_LO: begin
				for (int b = 0; b < 4; b++) begin
					w[DIT_BYTE_W*b +: DIT_FN_W] = st.func[b];
				end
			end
			DIT_OFS_FUNC_HI: begin
				for (int b = 0; b < 4; b++) begin
					w[DIT_BYTE_W*b +: DIT_FN_W] = st.func[b+4];
				end
			end
			DIT_OFS_CFG: w[DIT_CFG_W-1:0] = st.cfg;
			DIT_OFS_STAT: w[DIT_STAT_W-1:0] = {st.ext_hold, st.cmd.jog_rev_op,
				st.cmd.jog_fwd_op, st.cmd.op_mode, st.cmd.ramp_set, st.cmd.s_curve,
				st.cmd.ramp_hold, st.cmd.wobble_on, st.cmd.dc_brake, st.cmd.coast,
				st.cmd.out_cut};
			default: w = '0;
		endcase
		return w;
	endfunction : rd_word

	assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
	assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;
	assign cmd           = s_reg.cmd;

	logic sep_jog;
	logic j1f;
	logic j1r;
	logic jf;
	logic jr;
	logic jog_now;
	logic force_norm;
	logic ext_in;
	logic coast_in;
	logic brk_win;

	always_comb begin
		sep_jog    = fasg[FN_JOG1_F] || fasg[FN_JOG1_R];
		j1f        = sep_jog ? fa[FN_JOG1_F] : (fa[FN_JOG_CMD] && !fa[FN_JOG_DIR]);
		j1r        = sep_jog ? fa[FN_JOG1_R] : (fa[FN_JOG_CMD] && fa[FN_JOG_DIR]);
		jf         = j1f || fa[FN_JOG2_F];
		jr         = j1r || fa[FN_JOG2_R];
		// both directions at once cancel rather than pick a winner
		jog_now    = jf ^ jr;
		force_norm = fa[FN_NORMAL];
		ext_in     = fa[FN_EXT_NO] || fa[FN_EXT_NC];
		coast_in   = fa[FN_FREE_NO] || fa[FN_FREE_NC];
		brk_win    = drv.decel_stop || drv.stopping;
	end

	always_comb begin
		s_next = s_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_got  = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got  = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp  = addr_ok(s_reg.aw_addr) ? DIT_RESP_OKAY : DIT_RESP_SLVERR;
			// each byte lane holds one terminal's function code
			for (int b = 0; b < 4; b++) begin
				if (s_reg.wstrb[b] && s_reg.aw_addr == DIT_OFS_FUNC_LO) begin
					s_next.func[b] = s_reg.wdata[DIT_BYTE_W*b +: DIT_FN_W];
				end
				if (s_reg.wstrb[b] && s_reg.aw_addr == DIT_OFS_FUNC_HI) begin
					s_next.func[b+4] = s_reg.wdata[DIT_BYTE_W*b +: DIT_FN_W];
				end
			end
			if (s_reg.wstrb[0] && s_reg.aw_addr == DIT_OFS_CFG) begin
				s_next.cfg = s_reg.wdata[DIT_CFG_W-1:0];
			end
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd_word(s_axi_araddr, s_reg);
			s_next.rresp  = addr_ok(s_axi_araddr) ? DIT_RESP_OKAY : DIT_RESP_SLVERR;
		end

		s_next.cmd.aux_zero   = fa[FN_AUX_CLR];
		s_next.cmd.jog_fwd_op = jog_now && jf;
		s_next.cmd.jog_rev_op = jog_now && jr;
		s_next.cmd.jog2_sel   = jog_now && !(j1f || j1r);

		case ({fasg[FN_RSEL2], fasg[FN_RSEL1]})
			2'b11: s_next.cmd.ramp_set = {fa[FN_RSEL2], fa[FN_RSEL1]};
			2'b10: s_next.cmd.ramp_set = {1'b0, fa[FN_RSEL2]};
			2'b01: s_next.cmd.ramp_set = {1'b0, fa[FN_RSEL1]};
			default: s_next.cmd.ramp_set = 2'b00;
		endcase

		s_next.cmd.s_curve = fasg[FN_SCURVE] ? fa[FN_SCURVE]
			: s_reg.cfg[DIT_CFG_RAMP_S];
		s_next.cmd.ramp_hold = fa[FN_RHOLD] && !drv.stop_cmd
			&& !drv.decel_stop;

		if (jog_now) begin
			s_next.cmd.op_mode = OPM_JOG;
		end else if (force_norm) begin
			s_next.cmd.op_mode = OPM_NORMAL;
		end else if (drv.pid_req && !fa[FN_PID_INH]) begin
			s_next.cmd.op_mode = OPM_PID;
		end else if (drv.mspd_req) begin
			s_next.cmd.op_mode = OPM_MSPD;
		end else if (drv.seq_req) begin
			s_next.cmd.op_mode = OPM_SEQ;
		end else begin
			s_next.cmd.op_mode = OPM_NORMAL;
		end

		s_next.cmd.seq_mem_clr  = fa[FN_SEQ_CLR];
		s_next.cmd.pid_pause    = fa[FN_PID_PAUSE];
		s_next.cmd.pid_int_clr  = fa[FN_INT_CLR];
		// clearing wins over holding so a held integrator can still be zeroed
		s_next.cmd.pid_int_hold = fa[FN_INT_HOLD] && !fa[FN_INT_CLR];

		s_next.cmd.wobble_clr = s_reg.cfg[DIT_CFG_SWING_EN] && fa[FN_SWING_RST];
		if (!s_reg.cfg[DIT_CFG_SWING_EN] || force_norm) begin
			s_next.cmd.wobble_on = 1'b0;
		end else if (s_reg.cfg[DIT_CFG_SWING_MAN]) begin
			s_next.cmd.wobble_on = fa[FN_SWING];
		end else begin
			s_next.cmd.wobble_on = drv.run_on;
		end

		if (fa[FN_DC_BRK] && brk_win && !drv.motor_stopped) begin
			s_next.cmd.dc_brake = 1'b1;
		end else if (drv.motor_stopped || !fa[FN_DC_BRK] || !brk_win) begin
			s_next.cmd.dc_brake = 1'b0;
		end

		s_next.cmd.flying_start = 1'b0;
		if (ext_in && drv.run_on) begin
			s_next.ext_hold = 1'b1;
		end else if (s_reg.ext_hold && !ext_in && drv.run_ok) begin
			s_next.ext_hold         = 1'b0;
			s_next.cmd.flying_start = 1'b1;
		end
		s_next.cmd.coast   = coast_in;
		s_next.cmd.out_cut = s_next.ext_hold || coast_in;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= DIT_STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_aux_zero_out:
	assert property (fa[FN_AUX_CLR] |=> cmd.aux_zero)
		else $error("aux clear did not zero auxiliary frequency");

	a_jog_cmd_dir:
	assert property (!sep_jog && !fa[FN_JOG2_F] && !fa[FN_JOG2_R]
		|=> (cmd.jog_fwd_op == $past(fa[FN_JOG_CMD] && !fa[FN_JOG_DIR]))
		&& (cmd.jog_rev_op == $past(fa[FN_JOG_CMD] && fa[FN_JOG_DIR])))
		else $error("command/direction jog decoded wrongly");

	a_jog_sep_only:
	assert property (sep_jog && !fa[FN_JOG1_F] && !fa[FN_JOG1_R]
		&& !fa[FN_JOG2_F] && !fa[FN_JOG2_R] |=> !cmd.jog_fwd_op && !cmd.jog_rev_op)
		else $error("command/direction jog acted with separate inputs assigned");

	a_ramp_four_sets:
	assert property (fasg[FN_RSEL1] && fasg[FN_RSEL2]
		|=> cmd.ramp_set == {$past(fa[FN_RSEL2]), $past(fa[FN_RSEL1])})
		else $error("ramp set not taken from both selects");

	a_ramp_two_sets:
	assert property (fasg[FN_RSEL1] && !fasg[FN_RSEL2]
		|=> cmd.ramp_set == {1'b0, $past(fa[FN_RSEL1])})
		else $error("single select did not pick between two sets");

	a_ramp_shape_pick:
	assert property (fasg[FN_SCURVE] ##1 fasg[FN_SCURVE]
		|-> cmd.s_curve == $past(fa[FN_SCURVE]))
		else $error("ramp shape terminal not obeyed");

	a_hold_stop_wins:
	assert property (fa[FN_RHOLD] && (drv.stop_cmd || drv.decel_stop) |=> !cmd.ramp_hold)
		else $error("ramp held against stop or deceleration");

	a_force_normal:
	assert property (force_norm && !jog_now |=> cmd.op_mode == OPM_NORMAL
		&& !cmd.wobble_on)
		else $error("force normal did not select normal mode");

	a_seq_mem_clear:
	assert property (fa[FN_SEQ_CLR] |=> cmd.seq_mem_clr)
		else $error("sequencer memory clear missing");

	a_pid_pause_out:
	assert property (fa[FN_PID_PAUSE] |=> cmd.pid_pause)
		else $error("pid pause missing");

	a_pid_inhibit:
	assert property (fa[FN_PID_INH] |=> cmd.op_mode != OPM_PID)
		else $error("pid kept while inhibited");

	a_jog_priority:
	assert property (jog_now |=> cmd.op_mode == OPM_JOG)
		else $error("jog did not take priority");

	a_int_hold_out:
	assert property (fa[FN_INT_HOLD] && !fa[FN_INT_CLR] |=> cmd.pid_int_hold)
		else $error("integrator hold missing");

	a_int_clear_out:
	assert property (fa[FN_INT_CLR] |=> cmd.pid_int_clr && !cmd.pid_int_hold)
		else $error("integrator clear missing");

	a_swing_manual:
	assert property (s_reg.cfg[DIT_CFG_SWING_EN] && s_reg.cfg[DIT_CFG_SWING_MAN]
		&& !force_norm && fa[FN_SWING] |=> cmd.wobble_on)
		else $error("manual swing did not enter wobble");

	a_swing_reset:
	assert property (s_reg.cfg[DIT_CFG_SWING_EN] && fa[FN_SWING_RST] |=> cmd.wobble_clr)
		else $error("swing reset did not clear wobble state");

	a_dc_brake_win:
	assert property (drv.motor_stopped || !brk_win |=> !cmd.dc_brake)
		else $error("dc brake outside stop window or after stop");

	a_ext_cut_out:
	assert property (ext_in && drv.run_on |=> cmd.out_cut && !cmd.flying_start)
		else $error("external interrupt did not cut output");

	a_flying_pulse:
	assert property (s_reg.ext_hold && !ext_in && drv.run_ok
		|=> cmd.flying_start && !s_reg.ext_hold ##1 !cmd.flying_start)
		else $error("flying start not one pulse after release");

	a_coast_cut:
	assert property (coast_in |=> cmd.coast && cmd.out_cut)
		else $error("freewheel did not cut output");

	a_nc_open_act:
	assert property (tcode[N_TERM-1] == FN_FREE_NC && !term_in[N_TERM-1] |=> cmd.coast)
		else $error("open normally closed contact not active");

	a_axi_write_resp:
	assert property (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid |=> s_axi_bvalid)
		else $error("write response not given");

endmodule : dit_input_terms

//--- rtl/dit_pkg.sv
// dit_pkg: constants, types and register map of the input terminal decoder
// assumes terminal levels and drive status are already synchronous to clk_sys
package dit_pkg;

	localparam int DIT_AW     = 8;
	localparam int DIT_N_TERM = 8;
	localparam int DIT_FN_W   = 6;
	localparam int DIT_N_FN   = 64;
	localparam int DIT_CFG_W  = 3;
	localparam int DIT_STAT_W = 14;
	localparam int DIT_BYTE_W = 8;

	localparam logic [DIT_AW-1:0] DIT_OFS_FUNC_LO = 8'h00;
	localparam logic [DIT_AW-1:0] DIT_OFS_FUNC_HI = 8'h04;
	localparam logic [DIT_AW-1:0] DIT_OFS_CFG     = 8'h08;
	localparam logic [DIT_AW-1:0] DIT_OFS_STAT    = 8'h0C;

	// config register bit positions
	localparam int DIT_CFG_RAMP_S    = 0; // ramp_method_param: 1 = s curve
	localparam int DIT_CFG_SWING_EN  = 1; // swing_enable_param
	localparam int DIT_CFG_SWING_MAN = 2; // swing_start_mode_param: 1 = manual

	localparam logic [1:0] DIT_RESP_OKAY   = 2'h0;
	localparam logic [1:0] DIT_RESP_SLVERR = 2'h2;

	// terminal function codes, 0 = no function
	localparam logic [DIT_FN_W-1:0] FN_AUX_CLR   = 6'h13;
	localparam logic [DIT_FN_W-1:0] FN_JOG1_F    = 6'h14;
	localparam logic [DIT_FN_W-1:0] FN_JOG1_R    = 6'h15;
	localparam logic [DIT_FN_W-1:0] FN_JOG2_F    = 6'h16;
	localparam logic [DIT_FN_W-1:0] FN_JOG2_R    = 6'h17;
	localparam logic [DIT_FN_W-1:0] FN_JOG_CMD   = 6'h18;
	localparam logic [DIT_FN_W-1:0] FN_JOG_DIR   = 6'h19;
	localparam logic [DIT_FN_W-1:0] FN_RSEL1     = 6'h1A;
	localparam logic [DIT_FN_W-1:0] FN_RSEL2     = 6'h1B;
	localparam logic [DIT_FN_W-1:0] FN_SCURVE    = 6'h1C;
	localparam logic [DIT_FN_W-1:0] FN_RHOLD     = 6'h1D;
	localparam logic [DIT_FN_W-1:0] FN_NORMAL    = 6'h1E;
	localparam logic [DIT_FN_W-1:0] FN_SEQ_CLR   = 6'h1F;
	localparam logic [DIT_FN_W-1:0] FN_PID_PAUSE = 6'h20;
	localparam logic [DIT_FN_W-1:0] FN_PID_INH   = 6'h21;
	localparam logic [DIT_FN_W-1:0] FN_INT_HOLD  = 6'h22;
	localparam logic [DIT_FN_W-1:0] FN_INT_CLR   = 6'h23;
	localparam logic [DIT_FN_W-1:0] FN_SWING     = 6'h24;
	localparam logic [DIT_FN_W-1:0] FN_SWING_RST = 6'h25;
	localparam logic [DIT_FN_W-1:0] FN_DC_BRK    = 6'h26;
	localparam logic [DIT_FN_W-1:0] FN_EXT_NO    = 6'h27;
	localparam logic [DIT_FN_W-1:0] FN_EXT_NC    = 6'h28;
	localparam logic [DIT_FN_W-1:0] FN_FREE_NO   = 6'h29;
	localparam logic [DIT_FN_W-1:0] FN_FREE_NC   = 6'h2A;

	typedef enum logic [2:0] {
		OPM_NORMAL,
		OPM_SEQ,
		OPM_MSPD,
		OPM_PID,
		OPM_JOG
	} dit_opmode_t;

	// status from the rest of the drive
	typedef struct packed {
		logic run_on;        // output running
		logic run_ok;        // run conditions met
		logic decel_stop;    // decelerating towards stop
		logic stopping;      // stop sequence active
		logic motor_stopped; // speed reached zero
		logic stop_cmd;      // stop command present
		logic pid_req;       // process pid selected
		logic mspd_req;      // multi-speed selected
		logic seq_req;       // sequencer selected
	} dit_drive_t;

	// commands to the rest of the drive
	typedef struct packed {
		logic        aux_zero;
		logic        jog_fwd_op;
		logic        jog_rev_op;
		logic        jog2_sel;
		logic [1:0]  ramp_set;
		logic        s_curve;
		logic        ramp_hold;
		dit_opmode_t op_mode;
		logic        seq_mem_clr;
		logic        pid_pause;
		logic        pid_int_hold;
		logic        pid_int_clr;
		logic        wobble_on;
		logic        wobble_clr;
		logic        dc_brake;
		logic        out_cut;
		logic        coast;
		logic        flying_start;
	} dit_cmd_t;

	typedef struct packed {
		logic                                aw_got;
		logic [DIT_AW-1:0]                   aw_addr;
		logic                                w_got;
		logic [31:0]                         wdata;
		logic [3:0]                          wstrb;
		logic                                bvalid;
		logic [1:0]                          bresp;
		logic                                rvalid;
		logic [31:0]                         rdata;
		logic [1:0]                          rresp;
		logic [DIT_N_TERM-1:0][DIT_FN_W-1:0] func;
		logic [DIT_CFG_W-1:0]                cfg;
		logic                                ext_hold;
		dit_cmd_t                            cmd;
	} dit_state_t;

	// all functions unassigned, config zero, outputs idle
	localparam dit_state_t DIT_STATE_RST = '0;

endpackage : dit_pkg

//--- rtl/dit_term_decode.sv
// dit_term_decode: maps terminal levels onto function-active flags
// assumes one function code per terminal; several terminals may share a code
`timescale 1ns/1ps
module dit_term_decode
	import dit_pkg::*;
#(
	parameter int N_TERM = DIT_N_TERM
) (
	input  wire logic [N_TERM-1:0]               level,    // terminal levels, 1 = closed
	input  wire logic [N_TERM-1:0][DIT_FN_W-1:0] code,     // function per terminal
	output logic      [DIT_N_FN-1:0]             active,   // function active
	output logic      [DIT_N_FN-1:0]             assigned  // function on some terminal
);

	function automatic logic is_nc(input logic [DIT_FN_W-1:0] c);
		return (c == FN_EXT_NC) || (c == FN_FREE_NC);
	endfunction : is_nc

	logic [N_TERM-1:0] eff;

	genvar t, c;
	generate
		for (t = 0; t < N_TERM; t++) begin : g_term
			// open contact means active for normally closed variants
			assign eff[t] = is_nc(code[t]) ? ~level[t] : level[t];
		end
		for (c = 0; c < DIT_N_FN; c++) begin : g_fn
			logic [N_TERM-1:0] hit;
			for (t = 0; t < N_TERM; t++) begin : g_hit
				assign hit[t] = (code[t] == DIT_FN_W'(c));
			end
			assign active[c]   = |(hit & eff);
			assign assigned[c] = |hit;
		end
	endgenerate

endmodule : dit_term_decode

//--- verification/dit_contacts.sv
// dit_contacts: switches and relay contacts wired to the input terminals
// assumes the bench sets the wanted contact state by nba just after a clock edge
`timescale 1ns/1ps
module dit_contacts
	import dit_pkg::*;
(
	input  wire logic                  clk_sys,  // drive clock
	input  wire logic [DIT_N_TERM-1:0] closed,   // wanted contact state
	output logic      [DIT_N_TERM-1:0] term_in   // level at the terminals
);
	// contacts settle on the clock, so the decoder never sees a mid-cycle change
	always_ff @(posedge clk_sys) begin
		term_in <= closed;
	end
endmodule : dit_contacts

//--- verification/tb_drive_input_terminal_functions.sv
// tb_drive_input_terminal_functions: self-checking bench of the terminal decoder
// assumes one cycle from terminals to commands and the axi timing of the hand-over
`timescale 1ns/1ps
module tb_drive_input_terminal_functions
	import dit_pkg::*;
;
	logic              clk_sys, rst_n;
	logic [7:0]        closed, term_in, s_axi_awaddr, s_axi_araddr;
	dit_drive_t        drv;
	dit_cmd_t          cmd;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	int                mismatches, tests_run;

	dit_contacts dit_contacts_inst (.clk_sys(clk_sys), .closed(closed), .term_in(term_in));

	dit_input_terms dit_input_terms_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .term_in(term_in), .drv(drv), .cmd(cmd),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic bound(input logic got, input string what);
		if (!got) begin
			mismatches++;
			$display("[FAIL] %s expected answer seen none", what);
			final_report();
		end
	endtask : bound

	// sampled at the falling edge, acted on at the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] rexp);
		int         n;
		logic       aw_t, w_t, b_t;
		logic [1:0] r;
		n = 0;
		b_t = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t && n < 40) begin
			@(negedge clk_sys);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			n++;
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		bound(b_t, "bvalid");
		chk("bresp", 32'(rexp), 32'(r));
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] dexp, input logic [1:0] rexp);
		int          n;
		logic        ar_t, r_t;
		logic [31:0] d;
		logic [1:0]  r;
		n = 0;
		r_t = 1'b0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t && n < 40) begin
			@(negedge clk_sys);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			n++;
			if (ar_t) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		bound(r_t, "rvalid");
		chk("rdata", dexp, d);
		chk("rresp", 32'(rexp), 32'(r));
	endtask : axi_rd

	// contacts need one edge, the decoder one more; look at the falling edge after
	task automatic drive(input logic [7:0] c, input dit_drive_t d);
		@(posedge clk_sys);
		closed <= c;
		drv <= d;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : drive

	initial begin
		mismatches = 0;
		tests_run = 0;
		rst_n = 1'b0;
		closed = 8'h00;
		drv = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		axi_rd(DIT_OFS_CFG, 32'h0000_0000, DIT_RESP_OKAY);
		axi_rd(DIT_OFS_FUNC_HI, 32'h0000_0000, DIT_RESP_OKAY);
		axi_rd(8'h10, 32'h0000_0000, DIT_RESP_SLVERR);
		axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, DIT_RESP_SLVERR);
		axi_wr(DIT_OFS_FUNC_LO, 32'h1918_1B1A, 4'hF, DIT_RESP_OKAY);
		axi_wr(DIT_OFS_FUNC_HI, 32'h2A1D_1C13, 4'hF, DIT_RESP_OKAY);
		axi_rd(DIT_OFS_FUNC_LO, 32'h1918_1B1A, DIT_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			drive(8'h80 | 8'(i), '0);
			chk("ramp_set", 32'(i), 32'(cmd.ramp_set));
		end
		for (int i = 0; i < 4; i++) begin
			drive(8'h80 | 8'(i << 2), '0);
			chk("jog_fwd_op", 32'(i == 1), 32'(cmd.jog_fwd_op));
			chk("jog_rev_op", 32'(i == 3), 32'(cmd.jog_rev_op));
			chk("op_mode", (i % 2) ? 32'(OPM_JOG) : 32'(OPM_NORMAL), 32'(cmd.op_mode));
		end
		drive(8'hF0, '0);
		chk("aux_zero", 32'h0000_0001, 32'(cmd.aux_zero));
		chk("s_curve", 32'h0000_0001, 32'(cmd.s_curve));
		chk("ramp_hold", 32'h0000_0001, 32'(cmd.ramp_hold));
		chk("coast", 32'h0000_0000, 32'(cmd.coast));
		drive(8'hF0, '{stop_cmd: 1'b1, default: 1'b0});
		chk("ramp_hold", 32'h0000_0000, 32'(cmd.ramp_hold));
		drive(8'hF0, '{decel_stop: 1'b1, default: 1'b0});
		chk("ramp_hold", 32'h0000_0000, 32'(cmd.ramp_hold));
		axi_wr(DIT_OFS_CFG, 32'h0000_0001, 4'h1, DIT_RESP_OKAY);
		drive(8'h80, '0);
		chk("s_curve", 32'h0000_0000, 32'(cmd.s_curve));
		drive(8'h00, '0);
		chk("coast", 32'h0000_0001, 32'(cmd.coast));
		chk("out_cut", 32'h0000_0001, 32'(cmd.out_cut));
		// one lane only: the other three terminal codes must survive
		axi_wr(DIT_OFS_FUNC_HI, 32'h0000_0014, 4'h1, DIT_RESP_OKAY);
		axi_rd(DIT_OFS_FUNC_HI, 32'h2A1D_1C14, DIT_RESP_OKAY);
		drive(8'h84, '0);
		chk("jog_fwd_op", 32'h0000_0000, 32'(cmd.jog_fwd_op));
		drive(8'h90, '0);
		chk("jog_fwd_op", 32'h0000_0001, 32'(cmd.jog_fwd_op));
		axi_wr(DIT_OFS_FUNC_LO, 32'h2021_2627, 4'hF, DIT_RESP_OKAY);
		drive(8'h80, '{pid_req: 1'b1, mspd_req: 1'b1, default: 1'b0});
		chk("op_mode", 32'(OPM_PID), 32'(cmd.op_mode));
		drive(8'h84, '{pid_req: 1'b1, mspd_req: 1'b1, default: 1'b0});
		chk("op_mode", 32'(OPM_MSPD), 32'(cmd.op_mode));
		drive(8'h88, '{pid_req: 1'b1, default: 1'b0});
		chk("pid_pause", 32'h0000_0001, 32'(cmd.pid_pause));
		drive(8'h82, '{stopping: 1'b1, default: 1'b0});
		chk("dc_brake", 32'h0000_0001, 32'(cmd.dc_brake));
		drive(8'h82, '{stopping: 1'b1, motor_stopped: 1'b1, default: 1'b0});
		chk("dc_brake", 32'h0000_0000, 32'(cmd.dc_brake));
		drive(8'h82, '0);
		chk("dc_brake", 32'h0000_0000, 32'(cmd.dc_brake));
		drive(8'h81, '0);
		chk("out_cut", 32'h0000_0000, 32'(cmd.out_cut));
		drive(8'h81, '{run_on: 1'b1, default: 1'b0});
		chk("out_cut", 32'h0000_0001, 32'(cmd.out_cut));
		// latched interrupt and output cut both visible in the status word
		axi_rd(DIT_OFS_STAT, 32'h0000_2001, DIT_RESP_OKAY);
		drive(8'h80, '{run_on: 1'b1, run_ok: 1'b1, default: 1'b0});
		chk("flying_start", 32'h0000_0001, 32'(cmd.flying_start));
		chk("out_cut", 32'h0000_0000, 32'(cmd.out_cut));
		@(negedge clk_sys);
		chk("flying_start", 32'h0000_0000, 32'(cmd.flying_start));
		axi_wr(DIT_OFS_FUNC_HI, 32'h2524_231F, 4'hF, DIT_RESP_OKAY);
		axi_wr(DIT_OFS_CFG, 32'h0000_0006, 4'h1, DIT_RESP_OKAY);
		drive(8'hF0, '{run_on: 1'b1, default: 1'b0});
		chk("seq_mem_clr", 32'h0000_0001, 32'(cmd.seq_mem_clr));
		chk("pid_int_clr", 32'h0000_0001, 32'(cmd.pid_int_clr));
		chk("wobble_on", 32'h0000_0001, 32'(cmd.wobble_on));
		chk("wobble_clr", 32'h0000_0001, 32'(cmd.wobble_clr));
		drive(8'h00, '{run_on: 1'b1, default: 1'b0});
		chk("wobble_on", 32'h0000_0000, 32'(cmd.wobble_on));
		axi_wr(DIT_OFS_FUNC_LO, 32'h0000_221E, 4'hF, DIT_RESP_OKAY);
		drive(8'h03, '{pid_req: 1'b1, default: 1'b0});
		chk("op_mode", 32'(OPM_NORMAL), 32'(cmd.op_mode));
		chk("pid_int_hold", 32'h0000_0001, 32'(cmd.pid_int_hold));
		// jog 2 reverse, single ramp select, automatic swing start
		axi_wr(DIT_OFS_FUNC_LO, 32'h0000_1A17, 4'hF, DIT_RESP_OKAY);
		axi_wr(DIT_OFS_CFG, 32'h0000_0002, 4'h1, DIT_RESP_OKAY);
		drive(8'h03, '{run_on: 1'b1, seq_req: 1'b1, default: 1'b0});
		chk("jog_rev_op", 32'h0000_0001, 32'(cmd.jog_rev_op));
		chk("jog2_sel", 32'h0000_0001, 32'(cmd.jog2_sel));
		chk("op_mode", 32'(OPM_JOG), 32'(cmd.op_mode));
		chk("ramp_set", 32'h0000_0001, 32'(cmd.ramp_set));
		chk("wobble_on", 32'h0000_0001, 32'(cmd.wobble_on));
		drive(8'h00, '{seq_req: 1'b1, default: 1'b0});
		chk("op_mode", 32'(OPM_SEQ), 32'(cmd.op_mode));
		chk("ramp_set", 32'h0000_0000, 32'(cmd.ramp_set));
		chk("wobble_on", 32'h0000_0000, 32'(cmd.wobble_on));
		final_report();
	end
endmodule : tb_drive_input_terminal_functions
